/* File: hw/sec_counter.sv */
`timescale 1ns/1ps
module sec_counter (
    input  wire logic                     i_clk,     // system clock
    input  wire logic                     i_rst_b,   // async reset, active low
    input  wire logic                     i_ce,      // clock enable
    input  wire logic                     i_scan,    // scan strobe, one cycle per scan
    input  wire sec_pkg::sec_mode_t       i_mode,    // counter variant
    input  wire logic                     i_count,   // count / up-count input
    input  wire logic                     i_down,    // down-count input
    input  wire logic                     i_reset,   // counter reset input
    input  wire logic [sec_pkg::CNT_W-1:0] i_preset, // preset value
    output logic                          o_contact, // output contact
    output logic [sec_pkg::CNT_W-1:0]     o_value    // current value
);
    import sec_pkg::*;

    sec_edge_if edges ();

    logic             contact;
    logic [CNT_W-1:0] value;
    logic             next_contact;
    logic [CNT_W-1:0] next_value;
    logic             rst_now;
    logic             count_seen;

    sec_edge_det u_det (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_ce    (i_ce),
        .i_scan  (i_scan),
        .i_up    (i_count),
        .i_dn    (i_down),
        .edges   (edges.det)
    );

    function automatic logic at_or_above(input logic [CNT_W-1:0] v, input logic [CNT_W-1:0] p);
        at_or_above = (v >= p);
    endfunction

    // reset is a program input, so it acts only at scan time
    assign rst_now = i_ce && i_scan && i_reset;

    // ----------------------------------------
    // next state per variant
    // ----------------------------------------
    always_comb begin
        next_value   = value;
        next_contact = contact;
        case (i_mode)
            SEC_INCREMENTING_COUNTER: begin
                if (rst_now) begin
                    next_contact = 1'b0;
                    next_value   = CNT_ZERO;
                end else begin
                    if (edges.up_edge && value != {CNT_W{1'b1}}) begin
                        next_value = value + CNT_ONE;
                    end
                    next_contact = at_or_above(next_value, i_preset);
                end
            end
            SEC_DECREMENTING_COUNTER: begin
                if (rst_now) begin
                    next_contact = 1'b0;
                    next_value   = i_preset;
                end else begin
                    if (edges.up_edge && value != CNT_ZERO) begin
                        next_value = value - CNT_ONE;
                    end
                    // counts down from preset; reaching zero fires the contact
                    next_contact = (next_value == CNT_ZERO);
                end
            end
            SEC_BIDIRECTIONAL_COUNTER: begin
                if (rst_now) begin
                    next_value = CNT_ZERO;
                end else if (edges.up_edge && !edges.dn_edge && value != {CNT_W{1'b1}}) begin
                    next_value = value + CNT_ONE;
                end else if (edges.dn_edge && !edges.up_edge && value != CNT_ZERO) begin
                    next_value = value - CNT_ONE;
                end
                next_contact = at_or_above(next_value, i_preset);
            end
            SEC_WRAPAROUND_COUNTER: begin
                if (rst_now) begin
                    next_contact = 1'b0;
                end else if (edges.up_edge) begin
                    if (contact) begin
                        next_value   = CNT_ZERO;
                        next_contact = 1'b0;
                    end else begin
                        next_value   = value + CNT_ONE;
                        next_contact = at_or_above(value + CNT_ONE, i_preset);
                    end
                end
            end
            default: begin
                next_value   = value;
                next_contact = contact;
            end
        endcase
    end

    // ----------------------------------------
    // state registers
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            value <= CNT_RST;
        end else if (i_ce) begin
            value <= next_value;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            contact <= 1'b0;
        end else if (i_ce && i_scan) begin
            // a preset moved between scans must not reach the contact early
            contact <= next_contact;
        end
    end

    assign o_value   = value;
    assign o_contact = contact;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    // count level at the previous strobe, kept apart from the detector
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            count_seen <= 1'b0;
        end else if (i_ce && i_scan) begin
            count_seen <= i_count;
        end
    end

    sequence s_held_high;
        i_ce && i_scan && i_count && count_seen && !i_reset && !edges.dn_edge;
    endsequence

    sequence s_ring_full;
        i_mode == SEC_WRAPAROUND_COUNTER && contact && edges.up_edge && !i_reset;
    endsequence

    sequence s_ring_count;
        i_mode == SEC_WRAPAROUND_COUNTER && !contact && edges.up_edge && !i_reset;
    endsequence

    a_up_step: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_mode == SEC_INCREMENTING_COUNTER && edges.up_edge && !i_reset && value != {CNT_W{1'b1}})
        |=> value == $past(value) + CNT_ONE)
        else $error("up count did not step by one");

    a_down_step: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_mode == SEC_DECREMENTING_COUNTER && edges.up_edge && !i_reset && value != CNT_ZERO)
        |=> value == $past(value) - CNT_ONE)
        else $error("down count did not step by one");

    a_no_level_count: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        s_held_high |=> value == $past(value))
        else $error("held input counted again");

    a_up_contact: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_ce && i_scan && i_mode == SEC_INCREMENTING_COUNTER && !i_reset)
        |=> contact == (value >= $past(i_preset)))
        else $error("up contact disagrees with preset");

    a_down_contact: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_ce && i_scan && i_mode == SEC_DECREMENTING_COUNTER && !i_reset)
        |=> contact == (value == CNT_ZERO))
        else $error("down contact disagrees with zero");

    a_reset_contact: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (rst_now && (i_mode == SEC_INCREMENTING_COUNTER || i_mode == SEC_DECREMENTING_COUNTER
         || i_mode == SEC_WRAPAROUND_COUNTER)) |=> !contact)
        else $error("reset left contact on");

    a_down_load: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (rst_now && i_mode == SEC_DECREMENTING_COUNTER) |=> value == $past(i_preset))
        else $error("down reset did not load preset");

    a_bidir_zero: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (rst_now && i_mode == SEC_BIDIRECTIONAL_COUNTER) |=> value == CNT_ZERO)
        else $error("bidirectional reset did not clear value");

    a_bidir_contact: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_ce && i_scan && i_mode == SEC_BIDIRECTIONAL_COUNTER)
        |=> contact == (value >= $past(i_preset)))
        else $error("bidirectional contact disagrees with preset");

    a_bidir_up: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_mode == SEC_BIDIRECTIONAL_COUNTER && edges.up_edge && !edges.dn_edge && !i_reset
         && value != {CNT_W{1'b1}}) |=> value == $past(value) + CNT_ONE)
        else $error("bidirectional up step wrong");

    a_bidir_steps: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_mode == SEC_BIDIRECTIONAL_COUNTER && edges.dn_edge && !edges.up_edge && !i_reset
         && value != CNT_ZERO) |=> value == $past(value) - CNT_ONE)
        else $error("bidirectional down step wrong");

    a_ring_step: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        s_ring_count |=> value == $past(value) + CNT_ONE)
        else $error("ring did not step by one");

    a_ring_wrap: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        s_ring_full |=> value == CNT_ZERO && !contact)
        else $error("ring did not wrap on next edge");

    a_ring_reset: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_mode == SEC_WRAPAROUND_COUNTER && rst_now) |=> !contact && value == $past(value))
        else $error("ring reset left contact on");

    a_scan_only: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (!i_scan && i_ce) |=> value == $past(value) && contact == $past(contact))
        else $error("state moved between scans");

    a_ce_freeze: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !i_ce |=> value == $past(value) && contact == $past(contact))
        else $error("state moved with clock enable low");
endmodule

/* File: hw/sec_pkg.sv */
// Overview of operation
// - each counter steps at most once per off-to-on input edge; held high counts nothing
// - incrementing mode adds one per detected count edge
// - decrementing mode subtracts one per detected count edge
// - incrementing mode asserts contact once current value reaches preset; decrementing mode once it reaches zero
// - incrementing/decrementing modes: reset deasserts the contact
// - bidirectional mode increments on up edges, decrements on down edges
// - bidirectional contact is high while current value at or above preset
// - bidirectional mode: reset forces current value to zero
// - wraparound increments, contact at preset, next edge clears value and contact
// - wraparound mode: reset clears the contact
package sec_pkg;
    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] CNT_RST  = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam int DUTY_DIV = 100;

    typedef enum logic [1:0] {
        SEC_INCREMENTING_COUNTER,
        SEC_DECREMENTING_COUNTER,
        SEC_BIDIRECTIONAL_COUNTER,
        SEC_WRAPAROUND_COUNTER
    } sec_mode_t;
endpackage

/* File: hw/sec_edge_if.sv */
`timescale 1ns/1ps
// carries sampled edge pulses from the detector to the counter core
interface sec_edge_if;
    logic up_edge;
    logic dn_edge;
    modport det  (output up_edge, output dn_edge);
    modport core (input up_edge, input dn_edge);
endinterface

/* File: hw/sec_edge_det.sv */
`timescale 1ns/1ps
module sec_edge_det (
    input  wire logic i_clk,      // system clock
    input  wire logic i_rst_b,    // async reset, active low
    input  wire logic i_ce,       // clock enable
    input  wire logic i_scan,     // scan strobe
    input  wire logic i_up,       // count / up-count input
    input  wire logic i_dn,       // down-count input
    sec_edge_if.det   edges       // edge pulses
);
    logic up_prev;
    logic dn_prev;

    // ----------------------------------------
    // previous-scan samples
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            up_prev <= 1'b0;
            dn_prev <= 1'b0;
        end else if (i_ce && i_scan) begin
            up_prev <= i_up;
            dn_prev <= i_dn;
        end
    end

    // only a strobe with low-then-high counts; holding high never repeats
    assign edges.up_edge = i_ce && i_scan && i_up && !up_prev;
    assign edges.dn_edge = i_ce && i_scan && i_dn && !dn_prev;

    a_edge_needs_low: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        edges.up_edge |-> !up_prev && i_scan)
        else $error("edge without prior low sample");

    a_sample_track: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_ce && i_scan) |=> up_prev == $past(i_up) && dn_prev == $past(i_dn))
        else $error("scan sample not taken at strobe");
endmodule

/* File: bench/sec_prog_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// controller program side: strobe and count lines
// ----------------------------------------
module sec_prog_model #(
    parameter int SCAN_P = 4
) (
    input  wire logic i_clk,   // system clock
    input  wire logic i_rst_b, // async reset, active low
    output logic      o_scan,  // scan strobe
    output logic      o_count, // count / up-count level
    output logic      o_down   // down-count level
);
    logic [7:0] phase;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            phase  <= 8'h00;
            o_scan <= 1'b0;
        end else begin
            phase  <= (phase == 8'(SCAN_P - 1)) ? 8'h00 : phase + 8'h01;
            o_scan <= (phase == 8'(SCAN_P - 1));
        end
    end

    initial begin
        o_count = 1'b0;
        o_down  = 1'b0;
    end

    task automatic wait_scans(input int n);
        repeat (n) @(posedge i_clk iff o_scan);
    endtask

    // each phase spans at least two strobes, so no edge can slip between scans
    task automatic pulse(input bit dn, input int hold);
        @(posedge i_clk);
        if (dn) o_down <= 1'b1; else o_count <= 1'b1;
        wait_scans(hold);
        if (dn) o_down <= 1'b0; else o_count <= 1'b0;
        wait_scans(2);
    endtask
endmodule

/* File: bench/sec_counter_tb_top.sv */
`timescale 1ns/1ps
module sec_counter_tb_top;
    import sec_pkg::*;
    logic             i_clk, i_rst_b, i_ce, i_scan, i_count, i_down, i_reset, o_contact;
    sec_mode_t        i_mode;
    logic [CNT_W-1:0] i_preset, o_value;
    int               fails, checked;

    sec_counter uut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_scan(i_scan), .i_mode(i_mode),
        .i_count(i_count), .i_down(i_down), .i_reset(i_reset), .i_preset(i_preset),
        .o_contact(o_contact), .o_value(o_value));
    sec_prog_model prog (.i_clk(i_clk), .i_rst_b(i_rst_b), .o_scan(i_scan), .o_count(i_count),
        .o_down(i_down));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic complete_run();
        if (fails == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic exp_c, input logic [CNT_W-1:0] exp_v);
        @(negedge i_clk);
        checked++;
        if (o_contact !== exp_c || o_value !== exp_v) begin
            fails++;
            $display("ERROR %s expected %0b/%0h seen %0b/%0h", what, exp_c, exp_v, o_contact, o_value);
        end
    endtask

    // reset is only acted on at a strobe, so hold it across two scans
    task automatic clr();
        @(posedge i_clk);
        i_reset <= 1'b1;
        prog.wait_scans(2);
        i_reset <= 1'b0;
        prog.wait_scans(1);
    endtask

    task automatic setup(input sec_mode_t m, input logic [CNT_W-1:0] p);
        @(posedge i_clk);
        i_mode   <= m;
        i_preset <= p;
        clr();
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_incr();
        setup(SEC_INCREMENTING_COUNTER, 16'h0003);
        chk("inc reset", 1'b0, 16'h0000);
        for (int i = 1; i <= 3; i++) begin
            prog.pulse(1'b0, (i == 2) ? 5 : 2);
            chk("inc step", (i == 3), CNT_W'(i));
        end
        clr();
        chk("inc clear", 1'b0, 16'h0000);
    endtask

    task automatic t_decr();
        setup(SEC_DECREMENTING_COUNTER, 16'h0002);
        chk("dec load", 1'b0, 16'h0002);
        prog.pulse(1'b0, 2);
        chk("dec step", 1'b0, 16'h0001);
        prog.pulse(1'b0, 4);
        chk("dec reach", 1'b1, 16'h0000);
        clr();
        chk("dec clear", 1'b0, 16'h0002);
    endtask

    task automatic t_bidir();
        setup(SEC_BIDIRECTIONAL_COUNTER, 16'h0002);
        chk("bid reset", 1'b0, 16'h0000);
        prog.pulse(1'b0, 2);
        prog.pulse(1'b0, 3);
        chk("bid up", 1'b1, 16'h0002);
        prog.pulse(1'b1, 2);
        chk("bid down", 1'b0, 16'h0001);
        prog.pulse(1'b0, 2);
        chk("bid again", 1'b1, 16'h0002);
        clr();
        chk("bid clear", 1'b0, 16'h0000);
    endtask

    task automatic t_ring();
        setup(SEC_WRAPAROUND_COUNTER, 16'h0002);
        prog.pulse(1'b0, 2);
        chk("ring one", 1'b0, 16'h0001);
        prog.pulse(1'b0, 2);
        chk("ring reach", 1'b1, 16'h0002);
        prog.pulse(1'b0, 2);
        chk("ring wrap", 1'b0, 16'h0000);
        prog.pulse(1'b0, 2);
        prog.pulse(1'b0, 2);
        clr();
        chk("ring clear", 1'b0, 16'h0002);
        // clock enable low must freeze even an acting strobe
        @(posedge i_clk);
        i_ce <= 1'b0;
        prog.pulse(1'b0, 2);
        chk("ring frozen", 1'b0, 16'h0002);
        @(posedge i_clk);
        i_ce <= 1'b1;
    endtask

    // ----------------------------------------
    // clock, reset, sequence, watchdog
    // ----------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    initial begin
        fails    = 0;
        checked  = 0;
        i_rst_b  = 1'b0;
        i_ce     = 1'b1;
        i_reset  = 1'b0;
        i_mode   = SEC_INCREMENTING_COUNTER;
        i_preset = 16'h0000;
        repeat (12) @(posedge i_clk);
        i_rst_b <= 1'b1;
        t_incr();
        t_decr();
        t_bidir();
        t_ring();
        complete_run();
    end

    // whole sequence needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge i_clk);
        fails++;
        complete_run();
    end
endmodule
